// ==== core/floppy_byte_fifo.sv ====
/*
  Synchronous byte FIFO with valid/ready on both sides and a level output.
  Assumes DEPTH is a power of two so the pointers wrap by themselves.
*/
`timescale 1ns/10ps

module floppy_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int LVL_W = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Occupancy
  output logic [LVL_W-1:0] level_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [LVL_W-1:0] level_r;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // Handshake decode
  // ----------------------------------------------------------------
  assign in_ready_o = level_r != LVL_W'(DEPTH);
  assign out_valid_o = level_r != '0;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_r[rd_ptr_r];
  assign level_o = level_r;

  // Pointers and level; clear drops contents without touching storage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r <= '0;
    end else if (clear_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      level_r <= level_r + LVL_W'(push) - LVL_W'(pop);
    end
  end

  // Storage needs no reset; unread words are never shown as valid
  always_ff @(posedge clk_i) begin
    if (push) mem_r[wr_ptr_r] <= in_data_i;
  end

endmodule // floppy_byte_fifo

// ==== core/floppy_phase_pkg.sv ====
/*
  Shared constants and types for the floppy phase sequencer and its FIFO.
  Assumes a single core clock domain; pins are synchronised inside the top.
*/
package floppy_phase_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int LVL_W = 5;

  // ----------------------------------------------------------------
  // FIFO level constants
  // ----------------------------------------------------------------
  localparam logic [LVL_W-1:0] LVL_ZERO = 5'h00;
  localparam logic [LVL_W-1:0] LVL_ONE = 5'h01;
  localparam logic [LVL_W-1:0] LVL_DEPTH = 5'h10;

  // ----------------------------------------------------------------
  // Byte counters
  // ----------------------------------------------------------------
  localparam logic [4:0] PIDX_ZERO = 5'h00;
  localparam logic [4:0] PIDX_ONE = 5'h01;
  localparam logic [3:0] RIDX_ZERO = 4'h0;
  localparam logic [3:0] RIDX_ONE = 4'h1;
  localparam logic [3:0] LEN_ZERO = 4'h0;

  // ----------------------------------------------------------------
  // Command kinds reported by the command decoder
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_TO_HOST = 2'h1;
  localparam logic [1:0] KIND_FROM_HOST = 2'h2;

  // ----------------------------------------------------------------
  // Phases
  // ----------------------------------------------------------------
  typedef enum {PH_CMD, PH_PROC, PH_EXEC, PH_RESULT} phase_t;

  // ----------------------------------------------------------------
  // Bus-side DMA pins, carried together through the synchroniser
  // ----------------------------------------------------------------
  typedef struct packed {
    logic dack_n;
    logic tc;
    logic ior_n;
    logic iow_n;
  } dma_pins_t;

  localparam dma_pins_t PINS_IDLE = '{dack_n: 1'b1, tc: 1'b0, ior_n: 1'b1, iow_n: 1'b1};

endpackage

// ==== core/floppy_phase_sequencer.sv ====
/*
  Command, execution and result phase control of a floppy controller core,
  with the data FIFO, its service threshold and DMA/non-DMA request logic.
  Assumes a command decoder and a disk engine on the same clock, and the
  DMA pins arriving asynchronously from the bus.
*/
// Function
// R1: Reset leads to command phase, ready.
// R2: Host writes only when request set, direction clear.
// R3: Host sends command and parameters in order.
// R4: Request flag clears after each command write.
// R5: Request reasserted per parameter unless command illegal.
// R6: After last parameter, request low, phase advances.
// R7: FIFO off after reset; byte mode until enabled.
// R8: Threshold is level parameter plus one.
// R9: Non-DMA read: interrupt/request at mark, drop empty.
// R10: Non-DMA write: request at entry, until full.
// R11: Non-DMA write: interrupt drops on count/acknowledge inactive.
// R12: Write transfers reach result only with FIFO empty.
// R13: DMA read: request at mark, drop on empty.
// R14: DMA read: last byte removes request on edge.
// R15: DMA write: request at entry, until full, rearm.
// R16: DMA write: qualified terminal count withdraws request.
// R17: DMA write: last byte removes request on edge.
// R18: End by count, error or last sector.
// R19: Finish sector on stop; implicit ends flag abnormal.
// R20: Host tolerates request during final FIFO drain.
// R21: Result phase starts with interrupt; host reads all.
// R22: After last result: request set, direction, busy clear.
`timescale 1ns/10ps

module floppy_phase_sequencer
  import floppy_phase_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic ARST_N_I,
  // Configuration
  input wire logic DMA_MODE_I,
  input wire logic FIFO_EN_I,
  input wire logic [3:0] FIFO_LEVEL_PARAM_I,
  input wire logic [7:0] LAST_SECTOR_NUMBER_I,
  // Host programmed-I/O access, same clock
  input wire logic HOST_WR_STB_I,
  input wire logic HOST_RD_STB_I,
  input wire logic [7:0] HOST_DATA_I,
  output logic [7:0] HOST_DATA_O,
  // Status flags
  output logic HOST_REQUEST_FLAG_O,
  output logic TRANSFER_DIRECTION_FLAG_O,
  output logic COMMAND_BUSY_FLAG_O,
  output logic CONTROLLER_INTERRUPT_O,
  // DMA pins, asynchronous
  input wire logic DMA_ACKNOWLEDGE_N_I,
  input wire logic TERMINAL_COUNT_I,
  input wire logic IO_READ_STROBE_N_I,
  input wire logic IO_WRITE_STROBE_N_I,
  output logic DMA_REQUEST_PIN_O,
  output logic DMA_REQUEST_ALT_O,
  // Command decoder
  output logic [7:0] CMD_CODE_O,
  output logic [7:0] PARAM_DATA_O,
  output logic [3:0] PARAM_IDX_O,
  output logic PARAM_STB_O,
  input wire logic CMD_ILLEGAL_I,
  input wire logic [3:0] CMD_PARAM_LEN_I,
  input wire logic [1:0] CMD_KIND_I,
  input wire logic [3:0] RESULT_LEN_I,
  input wire logic [7:0] RESULT_BYTE_I,
  output logic [3:0] RESULT_IDX_O,
  // Disk engine
  output logic EXEC_TO_HOST_O,
  output logic EXEC_FROM_HOST_O,
  input wire logic DISK_IN_VALID_I,
  output logic DISK_IN_READY_O,
  input wire logic [7:0] DISK_IN_DATA_I,
  output logic DISK_OUT_VALID_O,
  input wire logic DISK_OUT_READY_I,
  output logic [7:0] DISK_OUT_DATA_O,
  input wire logic SECTOR_END_I,
  input wire logic [7:0] SECTOR_NUM_I,
  input wire logic XFER_ERR_I,
  output logic XFER_STOP_O,
  output logic ABNORMAL_TERM_O
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  dma_pins_t pins_in;
  dma_pins_t sync1_r;
  dma_pins_t sync2_r;
  dma_pins_t sync3_r;

  assign pins_in = '{dack_n: DMA_ACKNOWLEDGE_N_I, tc: TERMINAL_COUNT_I,
                     ior_n: IO_READ_STROBE_N_I, iow_n: IO_WRITE_STROBE_N_I};

  // Third stage only feeds edge detection, never the first stage
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sync1_r <= PINS_IDLE;
      sync2_r <= PINS_IDLE;
      sync3_r <= PINS_IDLE;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  logic dack_lo;
  logic dack_fall;
  logic dack_rise;
  logic tc_fall;
  logic ior_fall;
  logic iow_fall;
  assign dack_lo = !sync2_r.dack_n;
  assign dack_fall = sync3_r.dack_n & !sync2_r.dack_n;
  assign dack_rise = !sync3_r.dack_n & sync2_r.dack_n;
  assign tc_fall = sync3_r.tc & !sync2_r.tc;
  assign ior_fall = sync3_r.ior_n & !sync2_r.ior_n;
  assign iow_fall = sync3_r.iow_n & !sync2_r.iow_n;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  phase_t phase_r;
  phase_t phase_nxt;
  logic [4:0] pidx_r;
  logic [3:0] plen_r;
  logic [1:0] kind_r;
  logic [3:0] ridx_r;
  logic req_r;
  logic req_nxt;
  logic irq_r;
  logic int_block_r;
  logic cb_r;
  logic stop_r;
  logic done_r;
  logic abn_r;
  logic sect_flush_r;
  logic [LVL_W-1:0] level;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;

  // ----------------------------------------------------------------
  // Command phase decode
  // ----------------------------------------------------------------
  logic in_cmd;
  logic in_proc;
  logic in_exec;
  logic in_res;
  logic cmd_wr;
  logic first;
  logic illegal;
  logic all_in;
  logic [3:0] need;
  logic [1:0] kind_cur;
  logic enter_exec;
  logic enter_res;
  logic res_rd;
  logic res_last;
  assign in_cmd = phase_r == PH_CMD;
  assign in_proc = phase_r == PH_PROC;
  assign in_exec = phase_r == PH_EXEC;
  assign in_res = phase_r == PH_RESULT;
  assign cmd_wr = in_cmd & HOST_WR_STB_I;
  assign first = pidx_r == PIDX_ONE;
  assign illegal = in_proc & first & CMD_ILLEGAL_I;
  assign need = first ? CMD_PARAM_LEN_I : plen_r;
  assign all_in = pidx_r == ({1'b0, need} + PIDX_ONE);
  assign kind_cur = first ? CMD_KIND_I : kind_r;
  assign enter_exec = in_proc & (phase_nxt == PH_EXEC);
  assign enter_res = !in_res & (phase_nxt == PH_RESULT);
  assign res_rd = in_res & HOST_RD_STB_I;
  assign res_last = res_rd & ((ridx_r + RIDX_ONE) >= RESULT_LEN_I);

  // ----------------------------------------------------------------
  // Execution data path decode
  // ----------------------------------------------------------------
  logic to_host;
  logic from_host;
  logic host_push;
  logic host_pop;
  logic [LVL_W-1:0] thr;
  logic [LVL_W-1:0] rd_mark;
  logic [LVL_W-1:0] wr_full;
  logic [LVL_W-1:0] wr_mark;
  logic fill_ok;
  logic fifo_empty;
  logic tc_hit;
  logic eot_hit;
  // Direction comes from the command decoder, latched on the code byte
  assign to_host = in_exec & (kind_r == KIND_TO_HOST);
  assign from_host = in_exec & (kind_r == KIND_FROM_HOST);
  assign host_push = from_host & !stop_r & (DMA_MODE_I ? (iow_fall & dack_lo) : HOST_WR_STB_I);
  assign host_pop = to_host & (DMA_MODE_I ? (ior_fall & dack_lo) : HOST_RD_STB_I);
  // FIFO disabled acts as a one-byte buffer: one request per byte
  assign thr = {1'b0, FIFO_LEVEL_PARAM_I} + LVL_ONE; // R8
  assign rd_mark = FIFO_EN_I ? (LVL_DEPTH - thr) : LVL_ONE; // R7
  assign wr_full = FIFO_EN_I ? LVL_DEPTH : LVL_ONE; // R7
  assign wr_mark = FIFO_EN_I ? thr : LVL_ZERO;
  assign fill_ok = level < wr_full;
  assign fifo_empty = level == LVL_ZERO;
  // Terminal count counts only when acknowledged in DMA mode
  assign tc_hit = sync2_r.tc & (DMA_MODE_I ? dack_lo : 1'b1); // R16
  assign eot_hit = SECTOR_END_I & (SECTOR_NUM_I == LAST_SECTOR_NUMBER_I);

  // FIFO held clear outside execution
  floppy_byte_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .LVL_W(LVL_W)
  ) u_fifo (
    .clk_i(CORE_CLK_I),
    .rst_n_i(ARST_N_I),
    .clear_i(!in_exec), // R7
    .in_valid_i(fill_ok & (from_host ? host_push : (to_host & DISK_IN_VALID_I))),
    .in_ready_o(fifo_in_ready),
    .in_data_i(from_host ? HOST_DATA_I : DISK_IN_DATA_I),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(to_host ? host_pop : (from_host & DISK_OUT_READY_I)),
    .out_data_o(fifo_out_data),
    .level_o(level)
  );

  assign DISK_IN_READY_O = to_host & fifo_in_ready & fill_ok;
  assign DISK_OUT_VALID_O = from_host & fifo_out_valid;
  assign DISK_OUT_DATA_O = fifo_out_data;

  // ----------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      PH_CMD: begin
        if (cmd_wr) phase_nxt = PH_PROC; // R4
      end
      PH_PROC: begin
        if (illegal) phase_nxt = PH_CMD; // R5
        else if (!all_in) phase_nxt = PH_CMD; // R5
        else if (kind_cur == KIND_NONE) phase_nxt = PH_RESULT; // R6
        else phase_nxt = PH_EXEC; // R6
      end
      PH_EXEC: begin
        if (done_r & fifo_empty) phase_nxt = PH_RESULT; // R12
      end
      PH_RESULT: begin
        if (res_last) phase_nxt = PH_CMD; // R22
      end
      default: phase_nxt = PH_CMD;
    endcase
  end

  // Phase register and command byte capture
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      phase_r <= PH_CMD; // R1
      pidx_r <= PIDX_ZERO;
      plen_r <= LEN_ZERO;
      kind_r <= KIND_NONE;
      CMD_CODE_O <= 8'h00;
      PARAM_DATA_O <= 8'h00;
      PARAM_IDX_O <= 4'h0;
      PARAM_STB_O <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      PARAM_STB_O <= cmd_wr & (pidx_r != PIDX_ZERO);
      if (cmd_wr) begin
        pidx_r <= pidx_r + PIDX_ONE;
        if (pidx_r == PIDX_ZERO) CMD_CODE_O <= HOST_DATA_I;
        else PARAM_DATA_O <= HOST_DATA_I;
        PARAM_IDX_O <= pidx_r[3:0] - RIDX_ONE;
      end
      if (in_proc & first) begin
        plen_r <= CMD_PARAM_LEN_I;
        kind_r <= CMD_KIND_I;
      end
      if (in_proc & (illegal | all_in)) pidx_r <= PIDX_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Termination tracking
  // ----------------------------------------------------------------
  // Stop asks the engine to finish the current sector, then it reports the end
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      stop_r <= 1'b0;
      done_r <= 1'b0;
      abn_r <= 1'b0;
      sect_flush_r <= 1'b0;
    end else if (enter_exec) begin
      stop_r <= 1'b0;
      done_r <= 1'b0;
      abn_r <= 1'b0;
      sect_flush_r <= 1'b0;
    end else if (in_exec) begin
      if (tc_hit | eot_hit | XFER_ERR_I) stop_r <= 1'b1; // R18
      if ((SECTOR_END_I & stop_r) | eot_hit | XFER_ERR_I) done_r <= 1'b1; // R19
      if ((eot_hit | XFER_ERR_I) & !stop_r) abn_r <= 1'b1; // R19
      if (SECTOR_END_I & to_host) sect_flush_r <= 1'b1;
      else if (fifo_empty) sect_flush_r <= 1'b0;
    end
  end

  assign XFER_STOP_O = stop_r;
  assign ABNORMAL_TERM_O = abn_r;
  assign EXEC_TO_HOST_O = to_host;
  assign EXEC_FROM_HOST_O = from_host;

  // ----------------------------------------------------------------
  // Service request
  // ----------------------------------------------------------------
  logic rd_set;
  logic rd_last;
  logic wr_set;
  logic wr_clr;
  logic wr_last;
  assign rd_set = !fifo_empty & ((level >= rd_mark) | sect_flush_r | done_r); // R9 R13
  assign rd_last = DMA_MODE_I & (sect_flush_r | done_r) & (level == LVL_ONE) & (dack_fall | ior_fall); // R14
  assign wr_set = (level <= wr_mark) & !stop_r; // R10 R15
  assign wr_clr = (level >= wr_full) | stop_r | tc_hit; // R16
  assign wr_last = DMA_MODE_I & sync2_r.tc & (dack_fall | iow_fall); // R17

  // Requests hold until full, empty, stop, terminal count or last byte, so the host sees no chatter
  always_comb begin
    req_nxt = req_r;
    if (enter_exec) req_nxt = kind_cur == KIND_FROM_HOST; // R10 R15
    else if (to_host) begin
      if (fifo_empty | rd_last) req_nxt = 1'b0; // R9 R13 R14
      else if (rd_set) req_nxt = 1'b1;
    end else if (from_host) begin
      if (wr_clr | wr_last) req_nxt = 1'b0; // R17
      else if (wr_set) req_nxt = 1'b1;
    end else req_nxt = 1'b0;
  end

  // Request, interrupt blocking, result interrupt and busy flag
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      req_r <= 1'b0;
      int_block_r <= 1'b0;
      irq_r <= 1'b0;
      cb_r <= 1'b0;
    end else begin
      req_r <= req_nxt;
      if (enter_exec | (req_nxt & !req_r)) int_block_r <= 1'b0;
      else if (from_host & (tc_fall | dack_rise)) int_block_r <= 1'b1; // R11
      // Set wins over a clear in the same cycle
      if (enter_res | illegal) irq_r <= 1'b1; // R21
      else if (res_rd | cmd_wr) irq_r <= 1'b0;
      if (cmd_wr) cb_r <= 1'b1;
      else if (res_last | illegal) cb_r <= 1'b0; // R22
    end
  end

  // ----------------------------------------------------------------
  // Result bytes and read data
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ridx_r <= RIDX_ZERO;
      HOST_DATA_O <= 8'h00;
    end else begin
      if (res_rd) HOST_DATA_O <= RESULT_BYTE_I; // R21
      else if (host_pop) HOST_DATA_O <= fifo_out_data;
      if (res_last | !in_res) ridx_r <= RIDX_ZERO;
      else if (res_rd) ridx_r <= ridx_r + RIDX_ONE;
    end
  end

  assign RESULT_IDX_O = ridx_r;

  // ----------------------------------------------------------------
  // Flag outputs
  // ----------------------------------------------------------------
  // Processing cycle keeps the request low after every command byte
  assign HOST_REQUEST_FLAG_O = in_cmd | in_res | (in_exec & !DMA_MODE_I & req_r); // R4 R6 R22
  assign TRANSFER_DIRECTION_FLAG_O = in_res | to_host;
  assign COMMAND_BUSY_FLAG_O = cb_r;
  assign CONTROLLER_INTERRUPT_O = irq_r | (in_exec & !DMA_MODE_I & req_r & !int_block_r); // R9 R11
  assign DMA_REQUEST_PIN_O = in_exec & DMA_MODE_I & req_r;
  assign DMA_REQUEST_ALT_O = in_exec & DMA_MODE_I & req_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_cmd_write_drops_request;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I) cmd_wr |=> !HOST_REQUEST_FLAG_O;
  endproperty
  a_cmd_write_drops_request: assert property (p_cmd_write_drops_request) // R4
    else $error("request flag still set after command write");

  property p_param_rearms;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I) (in_proc & !all_in & !illegal) |=> HOST_REQUEST_FLAG_O;
  endproperty
  a_param_rearms: assert property (p_param_rearms) // R5
    else $error("request flag not raised for next parameter");

  property p_last_param_leaves;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I) (in_proc & all_in & !illegal) |=> !in_cmd;
  endproperty
  a_last_param_leaves: assert property (p_last_param_leaves) // R6
    else $error("stayed in command phase after last parameter");

  property p_write_entry_request;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      (enter_exec & (kind_cur == KIND_FROM_HOST) & !DMA_MODE_I) |=> (HOST_REQUEST_FLAG_O & CONTROLLER_INTERRUPT_O);
  endproperty
  a_write_entry_request: assert property (p_write_entry_request) // R10
    else $error("no request on entering host-to-FIFO execution");

  property p_result_needs_empty;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      (in_res & ($past(phase_r) == PH_EXEC)) |-> ($past(level) == LVL_ZERO);
  endproperty
  a_result_needs_empty: assert property (p_result_needs_empty) // R12
    else $error("result phase entered with FIFO not empty");

  property p_dma_read_empty_drop;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I) (to_host & DMA_MODE_I & fifo_empty) |=> !DMA_REQUEST_PIN_O;
  endproperty
  a_dma_read_empty_drop: assert property (p_dma_read_empty_drop) // R13
    else $error("DMA request held with FIFO empty");

  property p_tc_withdraws;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      (from_host & DMA_MODE_I & sync2_r.tc & dack_lo) |=> !DMA_REQUEST_PIN_O [*2];
  endproperty
  a_tc_withdraws: assert property (p_tc_withdraws) // R16
    else $error("DMA request not withdrawn on terminal count");

  property p_result_interrupt;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I) enter_res |=> (in_res & CONTROLLER_INTERRUPT_O);
  endproperty
  a_result_interrupt: assert property (p_result_interrupt) // R21
    else $error("no interrupt at start of result phase");

  property p_ready_after_result;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      res_last |=> (HOST_REQUEST_FLAG_O & !TRANSFER_DIRECTION_FLAG_O & !COMMAND_BUSY_FLAG_O);
  endproperty
  a_ready_after_result: assert property (p_ready_after_result) // R22
    else $error("flags not ready for new command after results");

endmodule // floppy_phase_sequencer

// ==== testbench/dma_host_model.sv ====
/*
  Behavioural DMA controller on the bus side of the sequencer.
  Assumes one core clock; it issues four write cycles, terminal count on the last.
*/
`timescale 1ns/10ps

module dma_host_model (
  // Clock, reset, control
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic dreq_i,
  // Bus pins
  output logic dack_n_o,
  output logic iow_n_o,
  output logic tc_o
);
  int n;
  int k;

  // One cycle per request, strobe held for five edges so the synchroniser sees it
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dack_n_o <= 1'b1;
      iow_n_o <= 1'b1;
      tc_o <= 1'b0;
      n <= 0;
      k <= 0;
    end else if (k != 0) begin
      k <= k - 1;
      if (k == 1) begin
        dack_n_o <= 1'b1;
        iow_n_o <= 1'b1;
        tc_o <= 1'b0;
      end
    end else if (en_i && dreq_i && n < 4) begin
      dack_n_o <= 1'b0;
      iow_n_o <= 1'b0;
      tc_o <= (n == 3);
      n <= n + 1;
      k <= 5;
    end
  end
endmodule // dma_host_model

// ==== testbench/floppy_phase_sequencer_tb.sv ====
/*
  Self-checking bench for the floppy phase sequencer.
  Assumes the package, FIFO and DMA host model are compiled first.
*/
`timescale 1ns/10ps

module floppy_phase_sequencer_tb;
  import floppy_phase_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk = 0, rst_n = 0, dma = 0, fen = 0, wr = 0, rd = 0, ill = 0, ivld = 0, send = 0, go = 0;
  logic [3:0] plen = 4'h0, rlen = 4'h2, ridx;
  logic [1:0] kind = 2'h0;
  logic [7:0] din = 8'h5A, idat = 8'h00, snum = 8'h00, k = 8'h00, dout, code, pdat;
  logic dack_n, iow_n, tc, req, dir, busy, irq, dreq, ex_th, abn, iready, alt, xstop;
  int fail_count = 0, n_tests = 0, w;

  // 25 MHz core clock
  always #20 clk = ~clk;

  floppy_phase_sequencer DUT (.CORE_CLK_I(clk), .ARST_N_I(rst_n), .DMA_MODE_I(dma), .FIFO_EN_I(fen),
    .FIFO_LEVEL_PARAM_I(4'h3), .LAST_SECTOR_NUMBER_I(8'h09), .HOST_WR_STB_I(wr), .HOST_RD_STB_I(rd),
    .HOST_DATA_I(din), .HOST_DATA_O(dout), .HOST_REQUEST_FLAG_O(req), .TRANSFER_DIRECTION_FLAG_O(dir),
    .COMMAND_BUSY_FLAG_O(busy), .CONTROLLER_INTERRUPT_O(irq), .DMA_ACKNOWLEDGE_N_I(dack_n),
    .TERMINAL_COUNT_I(tc), .IO_READ_STROBE_N_I(1'b1), .IO_WRITE_STROBE_N_I(iow_n), .DMA_REQUEST_PIN_O(dreq),
    .DMA_REQUEST_ALT_O(alt), .CMD_CODE_O(code), .PARAM_DATA_O(pdat), .PARAM_IDX_O(), .PARAM_STB_O(),
    .CMD_ILLEGAL_I(ill), .CMD_PARAM_LEN_I(plen), .CMD_KIND_I(kind), .RESULT_LEN_I(rlen),
    .RESULT_BYTE_I({4'hA, ridx}),
    .RESULT_IDX_O(ridx), .EXEC_TO_HOST_O(ex_th), .EXEC_FROM_HOST_O(), .DISK_IN_VALID_I(ivld),
    .DISK_IN_READY_O(iready), .DISK_IN_DATA_I(idat), .DISK_OUT_VALID_O(), .DISK_OUT_READY_I(1'b1),
    .DISK_OUT_DATA_O(), .SECTOR_END_I(send), .SECTOR_NUM_I(snum), .XFER_ERR_I(1'b0), .XFER_STOP_O(xstop),
    .ABNORMAL_TERM_O(abn));

  dma_host_model M (.clk_i(clk), .rst_n_i(rst_n), .en_i(go), .dreq_i(dreq), .dack_n_o(dack_n),
    .iow_n_o(iow_n), .tc_o(tc));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task tick; @(posedge clk); #1; endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Flags looked at first; byte taken at the third edge, request low right after it
  task hwr(input logic [7:0] b);
    @(posedge clk); #1;
    chk("may_write", 8'h01, {dir, req});
    @(posedge clk); wr <= 1; din <= b;
    @(posedge clk); wr <= 0; #1;
    chk("req_low", 8'h00, req);
  endtask
  task cmd(input logic il, input logic [1:0] kd, input logic [3:0] p);
    @(posedge clk); ill <= il; kind <= kd; plen <= p;
    hwr(8'h46);
  endtask
  task hrd(input logic [7:0] e);
    @(posedge clk); rd <= 1;
    @(posedge clk); rd <= 0; #1;
    chk("data", e, dout);
  endtask
  // Engine pushes bytes 0x10, 0x11, ... into the FIFO, which has room
  task push(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk); ivld <= 1; idat <= 8'h10 + k; k = k + 1;
      @(posedge clk); ivld <= 0;
    end
    repeat (3) tick;
  endtask
  // Bounded wait; running out ends the run
  task wirq;
    for (w = 0; w < 300 && irq !== 1'b1; w++) tick;
    if (w == 300) begin fail_count++; report_and_stop; end
  endtask
  task sec_end(input logic [7:0] s);
    @(posedge clk); send <= 1; snum <= s;
    @(posedge clk); send <= 0; #1;
  endtask
  // Last-sector end with the FIFO empty, then both result bytes
  task eot_result;
    sec_end(8'h09); tick;
    chk("result_eot", 8'h0F, {req, dir, abn, irq});
    hrd(8'hA0); hrd(8'hA1);
    tick; chk("ready", 8'h04, {req, dir, busy});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    tick;
    chk("idle", 8'h10, {req, busy, dir, irq, dreq});
    // Non-DMA read, threshold 4: service at 12 bytes
    @(posedge clk); fen <= 1;
    cmd(0, KIND_TO_HOST, 4'h2);
    tick; chk("req_param", 8'h01, req);
    hwr(8'h01); tick; chk("req_param", 8'h01, req);
    hwr(8'h02); tick; chk("exec", 8'h02, {ex_th, req});
    chk("code", 8'h46, code);
    chk("param", 8'h02, pdat);
    push(11); chk("below_mark", 8'h00, {req, irq});
    push(1); chk("at_mark", 8'h07, {iready, req, irq});
    for (int i = 0; i < 12; i++) hrd(8'h10 + i[7:0]);
    tick; chk("empty", 8'h00, {req, irq});
    sec_end(8'h09); wirq; chk("result", 8'h07, {req, dir, abn});
    hrd(8'hA0); hrd(8'hA1);
    tick; chk("ready", 8'h04, {req, dir, busy});
    // DMA write, four bytes, terminal count on the last
    @(posedge clk); dma <= 1;
    cmd(0, KIND_FROM_HOST, 4'h0);
    tick; chk("dreq_entry", 8'h06, {dreq, alt, req});
    @(posedge clk); go <= 1;
    for (w = 0; w < 300 && !(M.n == 4 && dreq === 1'b0); w++) tick;
    if (w == 300) begin fail_count++; report_and_stop; end
    chk("dma_bytes", 8'h04, M.n[7:0]);
    chk("dreq_tc", 8'h00, dreq);
    chk("stop", 8'h01, xstop);
    sec_end(8'h01); wirq; chk("result_tc", 8'h06, {req, dir, abn});
    hrd(8'hA0); hrd(8'hA1);
    tick; chk("ready", 8'h04, {req, dir, busy});
    // DMA read from an empty FIFO: no request, ended on the last sector
    @(posedge clk); go <= 0;
    cmd(0, KIND_TO_HOST, 4'h0);
    tick; chk("dma_rd", 8'h02, {dir, dreq});
    eot_result;
    // Non-DMA write in byte mode: request and interrupt on entry
    @(posedge clk); dma <= 0; fen <= 0;
    cmd(0, KIND_FROM_HOST, 4'h0);
    tick; chk("wr_entry", 8'h03, {req, irq});
    eot_result;
    // Illegal code: no parameters requested, back to command phase
    cmd(1, KIND_NONE, 4'h2);
    wirq; chk("illegal", 8'h02, {req, busy});
    report_and_stop;
  end
endmodule // floppy_phase_sequencer_tb
